// >>> tms_map.svh
`ifndef TMS_MAP_SVH
`define TMS_MAP_SVH

// Register offsets (byte addresses)
`define TMS_OFF_CTRL     8'h00
`define TMS_OFF_STAT     8'h04
`define TMS_OFF_DATA     8'h08
`define TMS_OFF_IRQ      8'h0C
`define TMS_OFF_MASK     8'h10

// Control register field positions
`define TMS_CB_RATE_HI   7
`define TMS_CB_EN        6
`define TMS_CB_STA       5
`define TMS_CB_STO       4
`define TMS_CB_SI        3
`define TMS_CB_AA        2
`define TMS_CB_RATE_MID  1
`define TMS_CB_RATE_LO   0

// Status codes
`define TMS_ST_START     8'h08
`define TMS_ST_RSTART    8'h10
`define TMS_ST_AW_ACK    8'h18
`define TMS_ST_AW_NACK   8'h20
`define TMS_ST_D_ACK     8'h28
`define TMS_ST_D_NACK    8'h30
`define TMS_ST_ARB       8'h38
`define TMS_ST_AR_ACK    8'h40
`define TMS_ST_AR_NACK   8'h48
`define TMS_ST_NONE      8'hF8

// Interrupt status bits
`define TMS_IRQ_EVT      0
`define TMS_IRQ_ARB      1
`define TMS_IRQ_STOP     2

// Reset values
`define TMS_CTRL_RST     8'h00
`define TMS_DATA_RST     8'hFF
`define TMS_MASK_RST     3'h0

// Timing: one half of the link clock period at the fastest rate
`define TMS_CLK_NS       10
`define TMS_HALF_NS      1250
`define TMS_HALF_CYC     ((`TMS_HALF_NS + `TMS_CLK_NS - 1) / `TMS_CLK_NS)

`endif

// >>> tms_pkg.sv
package tms_pkg;

    typedef enum logic [3:0] {
        TMS_IDLE  = 4'h0,
        TMS_WFREE = 4'h1,
        TMS_ST_A  = 4'h2,
        TMS_ST_B  = 4'h3,
        TMS_ST_C  = 4'h4,
        TMS_BIT_LO = 4'h5,
        TMS_BIT_HI = 4'h6,
        TMS_SP_A  = 4'h7,
        TMS_SP_B  = 4'h8,
        TMS_SP_C  = 4'h9,
        TMS_HOLD  = 4'hA
    } tms_state_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } tms_lines_t;

    typedef struct packed {
        logic scl_o;
        logic scl_oe;
        logic sda_o;
        logic sda_oe;
    } tms_pins_t;

endpackage

// >>> tms_twi_master.sv
// Function
// R1 - Software asks repeated START: enable 1, start 1, stop 0, flag 0.
// R2 - After repeated START report 10h and keep bus ownership.
// R3 - At 08h software loads address+write; device sends it, samples acknowledge.
// R4 - At 10h address+write is sent with acknowledge, staying in transmit.
// R5 - At 10h address+read is sent, then hand-over to receive operation; the code reports 40h or 48h and then starts no further bus action.
// R6 - Address+write answered 18h on acknowledge, 20h on not-acknowledge.
// R7 - Data byte answered 28h on acknowledge, 30h on not-acknowledge.
// R8 - In 18h to 30h a loaded data byte is sent regardless of acknowledge.
// R9 - In 18h to 30h start 1 stop 0 gives a repeated START.
// R10 - In 18h to 30h stop 1 gives STOP, stop bit then cleared.
// R11 - Start and stop both 1 give STOP then START, stop bit cleared.
// R12 - Lost arbitration reports 38h; start 0 then releases the bus.
// R13 - At 38h start 1 waits for free bus then sends START.
// R14 - Each finished step sets the flag, updates status, holds clock low; at 38h the code releases the clock instead, and a finished STOP sets no flag.
// R15 - Nothing starts while the flag is set; clearing it starts the action.
// R16 - Data writes count only while the flag is set.
`timescale 1ns/1ps
`default_nettype none
`include "tms_map.svh"

module tms_twi_master (
    input  wire logic              clk_i,
    input  wire logic              nrst_i,
    input  wire logic [7:0]        addr_i,
    input  wire logic [7:0]        wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic [7:0]             rdata_o,
    input  wire tms_pkg::tms_lines_t lines_i,
    output tms_pkg::tms_pins_t     pins_o,
    output logic                   irq_o
);

    tms_pkg::tms_state_t state_q, state_d;
    logic [7:0]  status_q, status_d, data_q, data_d, shift_q, shift_d, rdata_q, rdata_d;
    logic [2:0]  rate_q, rate_d, irq_q, irq_d, mask_q, mask_d;
    logic [3:0]  bit_q, bit_d;
    logic [15:0] cnt_q, cnt_d, half_len;
    logic        en_q, en_d, sta_q, sta_d, sto_q, sto_d, si_q, si_d, aa_q, aa_d;
    logic        owner_q, owner_d, is_addr_q, is_addr_d, rw_q, rw_d, busy_q, busy_d;
    logic        scl_oe_q, scl_oe_d, sda_oe_q, sda_oe_d;
    logic        scl_m_q, sda_m_q, scl_s_q, sda_s_q, sda_p_q;
    logic        go, wsta, wsto, hi_st, half_done, ctl_wr;

    // Half period grows with the rate select field
    assign half_len = 16'(`TMS_HALF_CYC * (32'(rate_q) + 32'd1));
    assign hi_st = (state_q == tms_pkg::TMS_ST_B) || (state_q == tms_pkg::TMS_ST_C) ||
                   (state_q == tms_pkg::TMS_BIT_HI) || (state_q == tms_pkg::TMS_SP_B) ||
                   (state_q == tms_pkg::TMS_SP_C);
    assign half_done = (cnt_q == half_len - 16'h0001) && (!hi_st || scl_s_q);
    assign ctl_wr = wr_i && (addr_i == `TMS_OFF_CTRL);
    assign go = ctl_wr && si_q && !wdata_i[`TMS_CB_SI]; // R15
    assign wsta = wdata_i[`TMS_CB_STA];
    assign wsto = wdata_i[`TMS_CB_STO];

    always_comb begin
        state_d = state_q;
        status_d = status_q;
        data_d = data_q;
        shift_d = shift_q;
        rate_d = rate_q;
        irq_d = irq_q;
        mask_d = mask_q;
        bit_d = bit_q;
        en_d = en_q;
        sta_d = sta_q;
        sto_d = sto_q;
        si_d = si_q;
        aa_d = aa_q;
        owner_d = owner_q;
        is_addr_d = is_addr_q;
        rw_d = rw_q;
        scl_oe_d = scl_oe_q;
        sda_oe_d = sda_oe_q;
        rdata_d = 8'h00;
        busy_d = busy_q;
        if (scl_s_q && sda_p_q && !sda_s_q) begin
            busy_d = 1'b1;
        end else if (scl_s_q && !sda_p_q && sda_s_q) begin
            busy_d = 1'b0;
        end
        // Register port
        if (ctl_wr) begin
            rate_d = {wdata_i[`TMS_CB_RATE_HI], wdata_i[`TMS_CB_RATE_MID],
                      wdata_i[`TMS_CB_RATE_LO]};
            en_d = wdata_i[`TMS_CB_EN];
            sta_d = wsta;
            sto_d = wsto;
            aa_d = wdata_i[`TMS_CB_AA];
            si_d = si_q && wdata_i[`TMS_CB_SI];
        end
        if (wr_i && (addr_i == `TMS_OFF_DATA) && si_q) begin
            data_d = wdata_i; // R16
        end
        if (wr_i && (addr_i == `TMS_OFF_MASK)) begin
            mask_d = wdata_i[2:0];
        end
        if (rd_i) begin
            case (addr_i)
                `TMS_OFF_CTRL: rdata_d = {rate_q[2], en_q, sta_q, sto_q, si_q, aa_q, rate_q[1:0]};
                `TMS_OFF_STAT: rdata_d = status_q;
                `TMS_OFF_DATA: rdata_d = data_q;
                `TMS_OFF_IRQ:  rdata_d = {5'h00, irq_q};
                `TMS_OFF_MASK: rdata_d = {5'h00, mask_q};
                default:       rdata_d = 8'h00;
            endcase
            if (addr_i == `TMS_OFF_IRQ) begin
                irq_d = 3'h0;
            end
        end
        // Bus sequencer
        case (state_q)
            tms_pkg::TMS_IDLE: begin
                scl_oe_d = 1'b0;
                sda_oe_d = 1'b0;
                if (en_q && sta_q && !si_q) begin
                    state_d = tms_pkg::TMS_WFREE;
                end
            end
            tms_pkg::TMS_WFREE: begin
                if (!busy_q) begin
                    state_d = tms_pkg::TMS_ST_B; // R13
                end
            end
            tms_pkg::TMS_ST_A: begin
                scl_oe_d = 1'b1;
                sda_oe_d = 1'b0;
                if (half_done) state_d = tms_pkg::TMS_ST_B;
            end
            tms_pkg::TMS_ST_B: begin
                scl_oe_d = 1'b0;
                if (half_done) state_d = tms_pkg::TMS_ST_C;
            end
            tms_pkg::TMS_ST_C: begin
                sda_oe_d = 1'b1;
                if (half_done) begin
                    status_d = owner_q ? `TMS_ST_RSTART : `TMS_ST_START; // R2
                    owner_d = 1'b1;
                    si_d = 1'b1; // R14
                    irq_d[`TMS_IRQ_EVT] = 1'b1;
                    state_d = tms_pkg::TMS_HOLD;
                end
            end
            tms_pkg::TMS_BIT_LO: begin
                scl_oe_d = 1'b1;
                // Data moves only once the clock is already pulled low
                if (scl_oe_q) begin
                    sda_oe_d = (bit_q != 4'h8) && !shift_q[7];
                end
                if (half_done) state_d = tms_pkg::TMS_BIT_HI;
            end
            tms_pkg::TMS_BIT_HI: begin
                scl_oe_d = 1'b0;
                if (half_done) begin
                    if (bit_q != 4'h8 && !sda_oe_q && !sda_s_q) begin
                        status_d = `TMS_ST_ARB; // R12
                        si_d = 1'b1;
                        owner_d = 1'b0;
                        irq_d[`TMS_IRQ_EVT] = 1'b1;
                        irq_d[`TMS_IRQ_ARB] = 1'b1;
                        sda_oe_d = 1'b0;
                        state_d = tms_pkg::TMS_HOLD;
                    end else if (bit_q != 4'h8) begin
                        shift_d = {shift_q[6:0], 1'b1};
                        bit_d = bit_q + 4'h1;
                        state_d = tms_pkg::TMS_BIT_LO;
                    end else begin
                        if (!is_addr_q) begin
                            status_d = sda_s_q ? `TMS_ST_D_NACK : `TMS_ST_D_ACK; // R7
                        end else if (rw_q) begin
                            status_d = sda_s_q ? `TMS_ST_AR_NACK : `TMS_ST_AR_ACK; // R5
                        end else begin
                            status_d = sda_s_q ? `TMS_ST_AW_NACK : `TMS_ST_AW_ACK; // R6
                        end
                        si_d = 1'b1; // R14
                        irq_d[`TMS_IRQ_EVT] = 1'b1;
                        state_d = tms_pkg::TMS_HOLD;
                    end
                end
            end
            tms_pkg::TMS_SP_A: begin
                scl_oe_d = 1'b1;
                sda_oe_d = 1'b1;
                if (half_done) state_d = tms_pkg::TMS_SP_B;
            end
            tms_pkg::TMS_SP_B: begin
                scl_oe_d = 1'b0;
                if (half_done) state_d = tms_pkg::TMS_SP_C;
            end
            tms_pkg::TMS_SP_C: begin
                sda_oe_d = 1'b0;
                if (half_done) begin
                    sto_d = 1'b0; // R10
                    owner_d = 1'b0;
                    status_d = `TMS_ST_NONE;
                    irq_d[`TMS_IRQ_STOP] = 1'b1;
                    state_d = sta_q ? tms_pkg::TMS_ST_B : tms_pkg::TMS_IDLE; // R11
                end
            end
            tms_pkg::TMS_HOLD: begin
                scl_oe_d = (status_q != `TMS_ST_ARB); // R14
                if (go) begin // R15
                    if (status_q == `TMS_ST_ARB) begin
                        state_d = wsta ? tms_pkg::TMS_WFREE : tms_pkg::TMS_IDLE; // R12 R13
                    end else if (status_q >= `TMS_ST_AW_ACK && status_q <= `TMS_ST_D_NACK &&
                                 (wsta || wsto)) begin
                        state_d = wsto ? tms_pkg::TMS_SP_A : tms_pkg::TMS_ST_A; // R9 R10 R11
                    end else if (status_q == `TMS_ST_START || status_q == `TMS_ST_RSTART) begin
                        shift_d = data_q; // R3 R4 R5
                        rw_d = data_q[0];
                        is_addr_d = 1'b1;
                        bit_d = 4'h0;
                        state_d = tms_pkg::TMS_BIT_LO;
                    end else if (status_q >= `TMS_ST_AW_ACK && status_q <= `TMS_ST_D_NACK) begin
                        shift_d = data_q; // R8
                        is_addr_d = 1'b0;
                        bit_d = 4'h0;
                        state_d = tms_pkg::TMS_BIT_LO;
                    end
                end
            end
            default: state_d = tms_pkg::TMS_IDLE;
        endcase
        if (!en_q) begin
            // A disabled unit stops tracking bus ownership
            state_d = tms_pkg::TMS_IDLE;
            owner_d = 1'b0;
            busy_d = 1'b0;
            scl_oe_d = 1'b0;
            sda_oe_d = 1'b0;
        end
        if (state_d != state_q) begin
            cnt_d = 16'h0000;
        end else if (hi_st && !scl_s_q) begin
            cnt_d = cnt_q;
        end else begin
            cnt_d = cnt_q + 16'h0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            state_q <= tms_pkg::TMS_IDLE;
            status_q <= `TMS_ST_NONE;
            data_q <= `TMS_DATA_RST;
            shift_q <= `TMS_DATA_RST;
            rdata_q <= 8'h00;
            {rate_q[2], en_q, sta_q, sto_q, si_q, aa_q, rate_q[1:0]} <= `TMS_CTRL_RST;
            irq_q <= 3'h0;
            mask_q <= `TMS_MASK_RST;
            bit_q <= 4'h0;
            cnt_q <= 16'h0000;
            {owner_q, is_addr_q, rw_q, busy_q, scl_oe_q, sda_oe_q} <= 6'h00;
            {scl_m_q, sda_m_q, scl_s_q, sda_s_q, sda_p_q} <= 5'h1F;
        end else begin
            state_q <= state_d;
            status_q <= status_d;
            data_q <= data_d;
            shift_q <= shift_d;
            rdata_q <= rdata_d;
            {rate_q, en_q, sta_q, sto_q, si_q, aa_q} <= {rate_d, en_d, sta_d, sto_d, si_d, aa_d};
            irq_q <= irq_d;
            mask_q <= mask_d;
            bit_q <= bit_d;
            cnt_q <= cnt_d;
            {owner_q, is_addr_q, rw_q, busy_q} <= {owner_d, is_addr_d, rw_d, busy_d};
            {scl_oe_q, sda_oe_q} <= {scl_oe_d, sda_oe_d};
            {scl_m_q, sda_m_q} <= {lines_i.scl, lines_i.sda};
            {scl_s_q, sda_s_q, sda_p_q} <= {scl_m_q, sda_m_q, sda_s_q};
        end
    end

    assign rdata_o = rdata_q;
    assign pins_o = '{scl_o: 1'b0, scl_oe: scl_oe_q, sda_o: 1'b0, sda_oe: sda_oe_q};
    assign irq_o = |(irq_q & mask_q);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    chk_hold_scl_low: assert property ( // R14
        (state_q == tms_pkg::TMS_HOLD && status_q != `TMS_ST_ARB && en_q) |=> scl_oe_q)
        else $error("clock line not held low while flag set");
    chk_no_op_flag: assert property ( // R15
        (state_q == tms_pkg::TMS_HOLD && si_q && !go && en_q) |=> state_q == tms_pkg::TMS_HOLD)
        else $error("bus step started while flag set");
    chk_data_discard: assert property ( // R16
        (wr_i && addr_i == `TMS_OFF_DATA && !si_q) |=> data_q == $past(data_q))
        else $error("data write accepted with flag clear");
    chk_stop_clears: assert property ( // R10
        (state_q == tms_pkg::TMS_SP_C && half_done && en_q && !ctl_wr) |=> !sto_q)
        else $error("stop bit not cleared after stop");
    chk_addr_status: assert property ( // R6
        (state_q == tms_pkg::TMS_BIT_HI && half_done && bit_q == 4'h8 && is_addr_q && !rw_q
         && en_q) |=> si_q && (status_q == $past(sda_s_q ? `TMS_ST_AW_NACK : `TMS_ST_AW_ACK)))
        else $error("wrong address acknowledge status");
    chk_data_status: assert property ( // R7
        (state_q == tms_pkg::TMS_BIT_HI && half_done && bit_q == 4'h8 && !is_addr_q && en_q)
        |=> status_q == $past(sda_s_q ? `TMS_ST_D_NACK : `TMS_ST_D_ACK))
        else $error("wrong data acknowledge status");
    chk_rstart_code: assert property ( // R2
        (state_q == tms_pkg::TMS_ST_C && half_done && owner_q && en_q)
        |=> status_q == `TMS_ST_RSTART && owner_q)
        else $error("repeated start status wrong");
    chk_arb_release: assert property ( // R12
        (state_q == tms_pkg::TMS_BIT_HI && half_done && bit_q != 4'h8 && !sda_oe_q && !sda_s_q
         && en_q) |=> status_q == `TMS_ST_ARB ##1 !scl_oe_q && !sda_oe_q)
        else $error("arbitration loss not released");
    chk_wait_free: assert property ( // R13
        (state_q == tms_pkg::TMS_WFREE && busy_q && en_q) |=> state_q != tms_pkg::TMS_ST_B)
        else $error("start generated on busy bus");

    cov_start: cover property (state_q == tms_pkg::TMS_ST_C ##1 status_q == `TMS_ST_START);
    cov_rstart: cover property (status_q == `TMS_ST_RSTART && si_q);
    cov_data_ack: cover property (status_q == `TMS_ST_D_ACK && si_q);
    cov_arb: cover property (status_q == `TMS_ST_ARB && si_q);
    cov_stop: cover property (state_q == tms_pkg::TMS_SP_C ##1 state_q == tms_pkg::TMS_IDLE);

endmodule

`default_nettype wire

// >>> tms_slave_model.sv
`timescale 1ns/1ps
`default_nettype none

module tms_slave_model (
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    input  wire logic       ack_i,
    input  wire logic       steal_i,
    output logic            sda_low_o,
    output logic [7:0]      byte_o
);
    // Bit count since START; 4'hF means no frame on the wire
    logic [3:0] cnt_q;
    logic [7:0] sh_q;
    logic       scl_q;
    logic       sda_q;
    logic       ph_q;

    always_ff @(posedge clk_i) begin
        scl_q <= scl_i;
        sda_q <= sda_i;
        if (!nrst_i) begin
            cnt_q  <= 4'hF;
            ph_q   <= 1'b0;
            byte_o <= 8'h00;
        end else if (scl_q && scl_i && sda_q && !sda_i) begin
            cnt_q <= 4'h0;
            ph_q  <= 1'b0;
        end else if (scl_q && scl_i && !sda_q && sda_i) begin
            cnt_q <= 4'hF;
            ph_q  <= 1'b0;
        end else if (scl_q && !scl_i && ph_q) begin
            // Only a fall that closes a bit counts, not the one after START
            ph_q  <= 1'b0;
            cnt_q <= (cnt_q == 4'h8) ? 4'h0 : cnt_q + 4'h1;
        end else if (!scl_q && scl_i && cnt_q != 4'hF) begin
            ph_q <= 1'b1;
            if (cnt_q < 4'h8) begin
                sh_q <= {sh_q[6:0], sda_i};
            end
            if (cnt_q == 4'h7) begin
                byte_o <= {sh_q[6:0], sda_i};
            end
        end
    end

    // Acknowledge in the ninth bit; a competing master holds data low during the byte
    assign sda_low_o = (cnt_q == 4'h8 && ack_i)
                     || (steal_i && cnt_q < 4'h8);
endmodule

`default_nettype wire

// >>> tms_twi_master_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "tms_map.svh"

module tms_twi_master_tb_top;
    typedef struct packed {
        logic       ld;
        logic [7:0] d;
        logic       ack;
        logic [7:0] ctl;
        logic [7:0] st;
    } tms_row_t;

    logic                clk_i, nrst_i, wr_i, rd_i, irq_o, ack, steal, sda_low;
    logic [7:0]          addr_i, wdata_i, rdata_o, part_byte, v;
    tms_pkg::tms_lines_t lines;
    tms_pkg::tms_pins_t  pins;
    tms_row_t            rows [10];
    int                  fails = 0;
    int                  n_checks = 0;
    int                  cyc = 0;

    // Open-drain wires with pull-ups
    assign lines = {~pins.scl_oe, ~(pins.sda_oe | sda_low)};

    tms_twi_master u_tms_twi_master (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .lines_i(lines),
        .pins_o(pins), .irq_o(irq_o));
    tms_slave_model u_tms_slave_model (.clk_i(clk_i), .nrst_i(nrst_i), .scl_i(lines.scl),
        .sda_i(lines.sda), .ack_i(ack), .steal_i(steal), .sda_low_o(sda_low),
        .byte_o(part_byte));

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask

    task automatic rchk(input string name, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk(name, exp, d);
    endtask

    // Polls a register until the masked bits match, bounded
    task automatic wait_bit(input logic [7:0] a, input logic [7:0] m, input logic [7:0] val);
        logic [7:0] d;
        for (int i = 0; i < 3000; i++) begin
            rd(a, d);
            if ((d & m) === val) return;
        end
        chk("wait", val, d & m);
    endtask

    task automatic step(input logic [7:0] ctl);
        wr(`TMS_OFF_CTRL, ctl);
        wait_bit(`TMS_OFF_CTRL, 8'h08, 8'h08);
    endtask

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 90000) begin
            fails++;
            complete_run();
        end
    end

    initial begin
        nrst_i  = 1'b0;
        wr_i    = 1'b0;
        rd_i    = 1'b0;
        addr_i  = 8'h00;
        wdata_i = 8'h00;
        ack     = 1'b1;
        steal   = 1'b0;
        rows = '{'{1'b0, 8'h00, 1'b1, 8'h60, `TMS_ST_START},
                 '{1'b1, 8'hA4, 1'b1, 8'h40, `TMS_ST_AW_ACK},
                 '{1'b1, 8'h5A, 1'b1, 8'h40, `TMS_ST_D_ACK},
                 '{1'b1, 8'h3C, 1'b0, 8'h40, `TMS_ST_D_NACK},
                 '{1'b1, 8'hC3, 1'b1, 8'h40, `TMS_ST_D_ACK},
                 '{1'b0, 8'h00, 1'b0, 8'h60, `TMS_ST_RSTART},
                 '{1'b1, 8'hA6, 1'b0, 8'h40, `TMS_ST_AW_NACK},
                 '{1'b1, 8'h99, 1'b0, 8'h40, `TMS_ST_D_NACK},
                 '{1'b0, 8'h00, 1'b1, 8'h60, `TMS_ST_RSTART},
                 '{1'b1, 8'hA5, 1'b1, 8'h40, `TMS_ST_AR_ACK}};
        repeat (4) @(posedge clk_i);
        nrst_i <= 1'b1;
        rchk("ctrl", `TMS_OFF_CTRL, `TMS_CTRL_RST);
        rchk("status", `TMS_OFF_STAT, `TMS_ST_NONE);
        rchk("mask", `TMS_OFF_MASK, 8'h00);
        wr(`TMS_OFF_DATA, 8'h12);
        wr(8'h20, 8'h55);
        rchk("data", `TMS_OFF_DATA, `TMS_DATA_RST);
        rchk("unmapped", 8'h20, 8'h00);
        $display("test reset done");

        foreach (rows[i]) begin
            ack <= rows[i].ack;
            if (rows[i].ld) wr(`TMS_OFF_DATA, rows[i].d);
            step(rows[i].ctl);
            rchk("status", `TMS_OFF_STAT, rows[i].st);
            if (rows[i].ld) chk("wire byte", rows[i].d, part_byte);
        end
        $display("test rows done");

        wr(`TMS_OFF_CTRL, 8'h00);
        repeat (2) @(negedge clk_i);
        chk("pins", 8'h00, {4'h0, pins});
        step(8'h60);
        wr(`TMS_OFF_DATA, 8'hA4);
        repeat (300) @(posedge clk_i);
        chk("scl hold", 8'h01, {7'h0, pins.scl_oe});
        rd(`TMS_OFF_CTRL, v);
        chk("flag", 8'h08, v & 8'h08);
        step(8'h40);
        wr(`TMS_OFF_DATA, 8'h5A);
        wr(`TMS_OFF_CTRL, 8'h40);
        wr(`TMS_OFF_DATA, 8'hEE);
        wait_bit(`TMS_OFF_CTRL, 8'h08, 8'h08);
        step(8'h40);
        rchk("status", `TMS_OFF_STAT, `TMS_ST_D_ACK);
        chk("resent", 8'h5A, part_byte);
        $display("test hold done");

        rd(`TMS_OFF_IRQ, v);
        chk("irq masked", 8'h00, {7'h0, irq_o});
        wr(`TMS_OFF_MASK, 8'h04);
        wr(`TMS_OFF_CTRL, 8'h50);
        wait_bit(`TMS_OFF_CTRL, 8'h10, 8'h00);
        repeat (4) @(posedge clk_i);
        rchk("status", `TMS_OFF_STAT, `TMS_ST_NONE);
        chk("pins", 8'h00, {4'h0, pins});
        chk("irq", 8'h01, {7'h0, irq_o});
        rchk("irq status", `TMS_OFF_IRQ, 8'h04);
        repeat (2) @(posedge clk_i);
        chk("irq clear", 8'h00, {7'h0, irq_o});
        $display("test stop done");

        step(8'h60);
        wr(`TMS_OFF_DATA, 8'hA4);
        step(8'h40);
        step(8'h70);
        rchk("status", `TMS_OFF_STAT, `TMS_ST_START);
        rd(`TMS_OFF_CTRL, v);
        chk("stop bit", 8'h08, v & 8'h18);
        $display("test stop start done");

        steal <= 1'b1;
        wr(`TMS_OFF_DATA, 8'hFF);
        step(8'h40);
        rchk("status", `TMS_OFF_STAT, `TMS_ST_ARB);
        rchk("irq status", `TMS_OFF_IRQ, 8'h07);
        wr(`TMS_OFF_CTRL, 8'h40);
        repeat (300) @(posedge clk_i);
        chk("released", 8'h00, {4'h0, pins});
        steal <= 1'b0;
        step(8'h60);
        steal <= 1'b1;
        wr(`TMS_OFF_DATA, 8'hFF);
        step(8'h40);
        wr(`TMS_OFF_CTRL, 8'h60);
        repeat (600) @(posedge clk_i);
        rd(`TMS_OFF_CTRL, v);
        chk("busy wait", 8'h00, v & 8'h08);
        steal <= 1'b0;
        wait_bit(`TMS_OFF_CTRL, 8'h08, 8'h08);
        rchk("status", `TMS_OFF_STAT, `TMS_ST_START);
        $display("test arbitration done");
        complete_run();
    end
endmodule

`default_nettype wire
